//--- aun_pkg.sv
// package for the alignment, update and nonvolatile-store control block
// assumes a single clock domain driven by the serial port clock
package aun_pkg;
   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [11:0] AUN_SYS_ADDR = 12'h230;
   localparam logic [11:0] AUN_UPD_ADDR = 12'h232;
   localparam logic [11:0] AUN_SEG_ADDR = 12'hA00;
   localparam logic [11:0] AUN_STAT_ADDR = 12'hB00;
   localparam logic [11:0] AUN_ERR_ADDR = 12'hB01;
   localparam logic [11:0] AUN_CTRL_ADDR = 12'hB02;
   localparam logic [11:0] AUN_STORE_ADDR = 12'hB03;
   localparam logic [11:0] AUN_CLKIN_ADDR = 12'h1E1;
   // ************************************************
   // field positions and sizes
   // ************************************************
   localparam int AUN_SEG_COUNT = 23;
   localparam int AUN_NVM_DEPTH = 256;
   localparam int AUN_BIT_NORUNT = 3;
   localparam int AUN_BIT_ALIGN_PD = 2;
   localparam int AUN_BIT_REF_PD = 1;
   localparam int AUN_BIT_SOFT_ALIGN = 0;
   localparam int AUN_BIT_CLKIN_PD = 4;
   localparam int AUN_BIT_RELOAD = 1;
   localparam int AUN_BIT_WR_EN = 0;
   // ************************************************
   // reset values and opcodes
   // ************************************************
   localparam logic [7:0] AUN_SYS_RESET = 8'h00;
   localparam logic [7:0] AUN_CLKIN_RESET = 8'h00;
   localparam logic [7:0] AUN_OP_UPDATE = 8'hA0;
   localparam logic [7:0] AUN_OP_END = 8'hFF;
   localparam logic [7:0] AUN_SEG_DEF0 = 8'h02;
   localparam logic [7:0] AUN_SEG_DEF1 = 8'h30;
   localparam logic [7:0] AUN_SEG_DEF2 = 8'h02;
   localparam logic [7:0] AUN_SEG_DEF3 = 8'h01;
   localparam logic [7:0] AUN_SEG_DEF4 = 8'hE1;
   localparam logic [7:0] AUN_SEG_DEF5 = 8'h00;
   // ************************************************
   // sequencer states
   // ************************************************
   typedef enum logic [2:0]
   {
      AUN_IDLE = 3'b000,
      AUN_FETCH = 3'b001,
      AUN_MOVE = 3'b010,
      AUN_UPDATE = 3'b011,
      AUN_DONE = 3'b100
   } aun_state_t;
endpackage : aun_pkg

//--- aun_cfg_if.sv
// interface carrying the staged register file path between top and sequencer
// assumes both ends share clk_in
`timescale 1ns/1ps
interface aun_cfg_if;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic [7:0] rdata;
   logic update;
   modport seq (output addr, output wdata, output wr, input rdata, output update);
   modport regs (input addr, input wdata, input wr, output rdata, input update);
endinterface : aun_cfg_if

//--- aun_nvm_seq.sv
// descriptor-driven sequencer moving staged registers to and from the store
// assumes descriptors are stable while a transfer runs
`timescale 1ns/1ps
module aun_nvm_seq
   import aun_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic store_in,
   input wire logic restore_in,
   input wire logic [7:0] seg_in [aun_pkg::AUN_SEG_COUNT],
   aun_cfg_if.seq cfg,
   output logic busy_out,
   output logic error_out,
   output logic done_out
);
   import aun_pkg::*;
   aun_state_t state;
   logic dir_store;
   logic [4:0] seg_idx;
   logic [7:0] cnt;
   logic [11:0] ptr;
   logic [7:0] nvm_ptr;
   logic [7:0] nvm [AUN_NVM_DEPTH];
   logic [AUN_NVM_DEPTH-1:0] nvm_par;
   logic [AUN_NVM_DEPTH-1:0] nvm_vld;
   wire [7:0] op_byte = seg_in[seg_idx];
   wire [7:0] lo_byte = (seg_idx < 5'd22) ? seg_in[seg_idx + 5'd1] : 8'h00;
   wire [7:0] n_byte = (seg_idx < 5'd21) ? seg_in[seg_idx + 5'd2] : 8'h00;
   // a byte never stored counts as bad, so an empty store cannot leak junk
   wire nvm_bad = !nvm_vld[nvm_ptr] || ((^nvm[nvm_ptr]) != nvm_par[nvm_ptr]);
   // store writes array, restore writes staged registers; bad bytes are skipped
   assign cfg.addr = ptr;
   assign cfg.wdata = nvm[nvm_ptr];
   assign cfg.wr = (state == AUN_MOVE) && !dir_store && !nvm_bad;
   assign cfg.update = (state == AUN_UPDATE);
   assign busy_out = (state != AUN_IDLE);
   assign done_out = (state == AUN_DONE);

   // ************************************************
   // descriptor walk: opcode byte, or {hi, lo, count-1}
   // ************************************************
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= AUN_IDLE;
         dir_store <= 1'b0;
         seg_idx <= 5'd0;
         cnt <= 8'h00;
         ptr <= 12'h000;
         nvm_ptr <= 8'h00;
         error_out <= 1'b0;
         nvm_vld <= {AUN_NVM_DEPTH{1'b0}};
      end
      else
      begin
         case (state)
            AUN_IDLE:
            begin
               if (store_in || restore_in)
               begin
                  state <= AUN_FETCH;
                  dir_store <= store_in;
                  seg_idx <= 5'd0;
                  nvm_ptr <= 8'h00;
                  error_out <= 1'b0;
               end
            end
            AUN_FETCH:
            begin
               if (op_byte == AUN_OP_END || seg_idx >= 5'd23)
                  state <= AUN_DONE;
               else if (op_byte == AUN_OP_UPDATE)
               begin
                  seg_idx <= seg_idx + 5'd1;
                  state <= dir_store ? AUN_FETCH : AUN_UPDATE;
               end
               else
               begin
                  ptr <= {op_byte[3:0], lo_byte};
                  cnt <= n_byte;
                  seg_idx <= seg_idx + 5'd3;
                  state <= AUN_MOVE;
               end
            end
            AUN_MOVE:
            begin
               if (!dir_store && nvm_bad)
                  error_out <= 1'b1;
               if (dir_store)
                  nvm_vld[nvm_ptr] <= 1'b1;
               ptr <= ptr + 12'h001;
               nvm_ptr <= nvm_ptr + 8'h01;
               cnt <= cnt - 8'h01;
               if (cnt == 8'h00)
                  state <= AUN_FETCH;
            end
            AUN_UPDATE: state <= AUN_FETCH;
            AUN_DONE: state <= AUN_IDLE;
            default: state <= AUN_IDLE;
         endcase
      end
   end

   // stored image with one parity bit per byte to catch corruption
   always_ff @(posedge clk_in)
   begin
      if (state == AUN_MOVE && dir_store)
      begin
         nvm[nvm_ptr] <= cfg.rdata;
         nvm_par[nvm_ptr] <= ^cfg.rdata;
      end
   end
endmodule : aun_nvm_seq

//--- aun_ctrl.sv
// top of the alignment, update and nonvolatile-store control block
// assumes a serial port front end presenting byte writes and reads on clk_in
`timescale 1ns/1ps
module aun_ctrl
   import aun_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   output logic [7:0] reg_rdata_out,
   input wire logic strap_nvm_in,
   output logic runt_suppress_out,
   output logic align_pd_out,
   output logic dist_ref_pd_out,
   output logic clkin_pd_out,
   output logic align_hold_out,
   output logic align_trigger_out,
   output logic soft_reset_out
);
   import aun_pkg::*;

   // ************************************************
   // pin synchroniser and register storage
   // ************************************************
   logic [2:0] strap_sync;
   logic strap_low;
   logic [7:0] sys_stage;
   logic [7:0] sys_active;
   logic [7:0] clkin_stage;
   logic [7:0] clkin_active;
   logic [7:0] seg [AUN_SEG_COUNT];
   logic wr_en;
   logic reload;
   logic store_req;
   logic soft_prev;
   logic busy;
   logic err;
   logic done;
   aun_cfg_if cfg ();

   // strap passes three flops; it counts once the last two agree
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         strap_sync <= 3'b111;
         strap_low <= 1'b0;
      end
      else
      begin
         strap_sync <= {strap_sync[1:0], strap_nvm_in};
         if (strap_sync[2] == strap_sync[1])
            strap_low <= !strap_sync[2];
      end
   end

   // host write decode; sequencer restore writes share the staged path
   wire host_sys = reg_wr_in && reg_addr_in == AUN_SYS_ADDR;
   wire host_clk = reg_wr_in && reg_addr_in == AUN_CLKIN_ADDR;
   wire host_upd = reg_wr_in && reg_addr_in == AUN_UPD_ADDR && reg_wdata_in[0];
   wire host_ctrl = reg_wr_in && reg_addr_in == AUN_CTRL_ADDR;
   wire host_store = reg_wr_in && reg_addr_in == AUN_STORE_ADDR && reg_wdata_in[0];
   wire seg_hit = reg_addr_in >= AUN_SEG_ADDR && reg_addr_in < AUN_SEG_ADDR + 12'd23;
   wire [4:0] seg_idx = 5'(reg_addr_in - AUN_SEG_ADDR);
   wire seq_sys = cfg.wr && cfg.addr == AUN_SYS_ADDR;
   wire seq_clk = cfg.wr && cfg.addr == AUN_CLKIN_ADDR;
   wire do_update = host_upd || cfg.update;
   wire store_go = host_store && wr_en && !busy;
   wire reload_go = host_ctrl && reg_wdata_in[AUN_BIT_RELOAD] && strap_low && !busy;

   // ************************************************
   // staged and active registers
   // ************************************************
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sys_stage <= AUN_SYS_RESET;
         sys_active <= AUN_SYS_RESET;
         clkin_stage <= AUN_CLKIN_RESET;
         clkin_active <= AUN_CLKIN_RESET;
      end
      else
      begin
         if (host_sys)
            sys_stage <= reg_wdata_in;
         else if (seq_sys)
            sys_stage <= cfg.wdata;
         if (host_clk)
            clkin_stage <= reg_wdata_in;
         else if (seq_clk)
            clkin_stage <= cfg.wdata;
         if (do_update)
         begin
            sys_active <= sys_stage;
            clkin_active <= clkin_stage;
         end
      end
   end

   // descriptors default to: sys regs, clock input reg, update, end
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < AUN_SEG_COUNT; i++)
            seg[i] <= AUN_OP_END;
         seg[0] <= AUN_SEG_DEF0;
         seg[1] <= AUN_SEG_DEF1;
         seg[2] <= AUN_SEG_DEF2;
         seg[3] <= AUN_SEG_DEF3;
         seg[4] <= AUN_SEG_DEF4;
         seg[5] <= AUN_SEG_DEF5;
         seg[6] <= AUN_OP_UPDATE;
      end
      else if (reg_wr_in && seg_hit && !busy)
         seg[seg_idx] <= reg_wdata_in;
   end

   // control bits; self-clearing bits ease off without host help
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_en <= 1'b0;
         reload <= 1'b0;
         store_req <= 1'b0;
         soft_prev <= 1'b0;
      end
      else
      begin
         if (host_ctrl)
            wr_en <= reg_wdata_in[AUN_BIT_WR_EN];
         reload <= reload_go;
         if (store_go)
            store_req <= 1'b1;
         else if (done)
            store_req <= 1'b0;
         soft_prev <= sys_active[AUN_BIT_SOFT_ALIGN];
      end
   end

   aun_nvm_seq u_seq
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .store_in(store_go),
      .restore_in(reload_go),
      .seg_in(seg),
      .cfg(cfg.seq),
      .busy_out(busy),
      .error_out(err),
      .done_out(done)
   );

   // staged read path used by the sequencer when storing
   assign cfg.rdata = (cfg.addr == AUN_SYS_ADDR) ? sys_stage :
                      (cfg.addr == AUN_CLKIN_ADDR) ? clkin_stage : 8'h00;

   // ************************************************
   // outputs into the analog side
   // ************************************************
   assign runt_suppress_out = !sys_active[AUN_BIT_NORUNT];
   assign align_pd_out = sys_active[AUN_BIT_ALIGN_PD];
   assign dist_ref_pd_out = sys_active[AUN_BIT_REF_PD];
   assign clkin_pd_out = clkin_active[AUN_BIT_CLKIN_PD];
   assign align_hold_out = sys_active[AUN_BIT_SOFT_ALIGN];
   assign align_trigger_out = soft_prev && !sys_active[AUN_BIT_SOFT_ALIGN];
   assign soft_reset_out = reload;

   // register readback; unmapped reads give zero
   always_comb
   begin
      reg_rdata_out = 8'h00;
      if (reg_addr_in == AUN_SYS_ADDR)
         reg_rdata_out = sys_stage;
      else if (reg_addr_in == AUN_CLKIN_ADDR)
         reg_rdata_out = clkin_stage;
      else if (seg_hit)
         reg_rdata_out = seg[seg_idx];
      else if (reg_addr_in == AUN_STAT_ADDR)
         reg_rdata_out = {7'h00, busy};
      else if (reg_addr_in == AUN_ERR_ADDR)
         reg_rdata_out = {7'h00, err};
      else if (reg_addr_in == AUN_CTRL_ADDR)
         reg_rdata_out = {6'h00, reload, wr_en};
      else if (reg_addr_in == AUN_STORE_ADDR)
         reg_rdata_out = {7'h00, store_req};
   end
endmodule : aun_ctrl

//--- aun_ctrl_checker.sv
// port checker for the alignment, update and store control block
// assumes it is bound onto aun_ctrl and shares its clock and reset
`timescale 1ns/1ps
module aun_ctrl_checker
   import aun_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic runt_suppress_out,
   input wire logic align_pd_out,
   input wire logic dist_ref_pd_out,
   input wire logic clkin_pd_out,
   input wire logic align_hold_out,
   input wire logic align_trigger_out,
   input wire logic soft_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ************
   // helpers
   // ************
   // active outputs may only move after an update or inside a restore window
   logic upd_q;
   logic [5:0] win;
   wire logic upd_wr = reg_wr_in && reg_addr_in == AUN_UPD_ADDR && reg_wdata_in[0];
   wire logic may_chg = upd_q || soft_reset_out || win != 6'h00;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         upd_q <= 1'b0;
         win <= 6'h00;
      end
      else
      begin
         upd_q <= upd_wr;
         win <= soft_reset_out ? 6'h3F : win - {5'h00, win != 6'h00};
      end
   end
   // ************
   // properties
   // ************
   sequence s_pulse; align_trigger_out ##1 !align_trigger_out; endsequence
   property p_trig_one; align_trigger_out |-> s_pulse; endproperty
   property p_trig_fall; align_trigger_out |-> !align_hold_out && $past(align_hold_out); endproperty
   property p_soft_one; soft_reset_out |=> !soft_reset_out; endproperty
   property p_soft_cause;
      soft_reset_out |-> $past(reg_wr_in && reg_addr_in == AUN_CTRL_ADDR && reg_wdata_in[1]);
   endproperty
   property p_reload_clr;
      (reg_addr_in == AUN_CTRL_ADDR && !$past(reg_wr_in)) |-> !reg_rdata_out[AUN_BIT_RELOAD];
   endproperty
   property p_stage_runt; $changed(runt_suppress_out) |-> may_chg; endproperty
   property p_stage_pd; $changed(align_pd_out) |-> may_chg; endproperty
   property p_stage_ref; $changed(dist_ref_pd_out) |-> may_chg; endproperty
   property p_stage_clk; $changed(clkin_pd_out) |-> may_chg; endproperty
   a_trig_one: assert property (p_trig_one) else $error("trigger too long");
   a_trig_fall: assert property (p_trig_fall) else $error("bad trigger");
   a_soft_one: assert property (p_soft_one) else $error("soft reset too long");
   a_soft_cause: assert property (p_soft_cause) else $error("stray soft reset");
   a_reload_clr: assert property (p_reload_clr) else $error("reload bit stuck");
   a_stage_runt: assert property (p_stage_runt) else $error("runt moved early");
   a_stage_pd: assert property (p_stage_pd) else $error("align pd moved early");
   a_stage_ref: assert property (p_stage_ref) else $error("ref pd moved early");
   a_stage_clk: assert property (p_stage_clk) else $error("clk pd moved early");
endmodule : aun_ctrl_checker

//--- aun_host.sv
// host model for the register port of the control block
// assumes reads are combinational and settle before the falling edge
`timescale 1ns/1ps
module aun_host
(
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [11:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out
);
   initial
   begin
      addr_out = 12'h000;
      wdata_out = 8'h00;
      wr_out = 1'b0;
   end
   // one strobed byte; data inverted once released so stale values never look valid
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask : wr
   // address held for a cycle, data taken mid-cycle
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      @(negedge clk_in);
      d = rdata_in;
   endtask : rd
endmodule : aun_host

//--- align_update_nvm_control_test.sv
// self-checking bench for the control block
// assumes the package, interface, design, host model and checker are compiled first
`timescale 1ns/1ps
module align_update_nvm_control_test;
   import aun_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic strap_nvm_in = 1'b1;
   logic [11:0] addr;
   logic [7:0] wdata, rdata;
   logic wr, runt, apd, rpd, cpd, hold, trig, srst;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int pulses = 0;
   int srsts = 0;
   wire logic [7:0] pins = {3'h0, cpd, rpd, apd, runt, hold};
   aun_ctrl u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata),
      .strap_nvm_in(strap_nvm_in), .runt_suppress_out(runt), .align_pd_out(apd),
      .dist_ref_pd_out(rpd), .clkin_pd_out(cpd), .align_hold_out(hold),
      .align_trigger_out(trig), .soft_reset_out(srst));
   aun_host u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr));
   initial
   begin
      forever #2.5 clk_in = ~clk_in;
   end
   // pulse counters and hang guard; run needs well under a thousand cycles
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (trig === 1'b1) pulses <= pulses + 1;
      if (srst === 1'b1) srsts <= srsts + 1;
      if (cyc == 5000)
      begin
         num_errors++;
         complete_run();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_reg(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d & m, exp);
   endtask : chk_reg
   task automatic wait_idle();
      logic [7:0] d;
      d = 8'h01;
      for (int i = 0; i < 200 && d[0] !== 1'b0; i++) u_host.rd(AUN_STAT_ADDR, d);
      chk(d & 8'h01, 8'h00);
   endtask : wait_idle
   task automatic complete_run();
      $display("counts: %0d errors in %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk_reg(AUN_SYS_ADDR, 8'hFF, AUN_SYS_RESET);
      chk(pins, 8'h02);
      chk_reg(AUN_CTRL_ADDR, 8'h01, 8'h00);
      chk_reg(AUN_STAT_ADDR, 8'h01, 8'h00);
      $display("test reset done");
      u_host.wr(AUN_SYS_ADDR, 8'h0F);
      u_host.wr(AUN_CLKIN_ADDR, 8'h10);
      @(negedge clk_in);
      chk(pins, 8'h02);
      u_host.wr(AUN_UPD_ADDR, 8'h01);
      @(negedge clk_in);
      chk(pins, 8'h1D);
      u_host.wr(AUN_SYS_ADDR, 8'h00);
      u_host.wr(AUN_UPD_ADDR, 8'h01);
      repeat (3) @(negedge clk_in);
      chk(pulses[7:0], 8'h01);
      chk(pins, 8'h12);
      $display("test staging done");
      u_host.wr(AUN_CTRL_ADDR, 8'h03);
      repeat (3) @(negedge clk_in);
      chk(srsts[7:0], 8'h00);
      @(posedge clk_in);
      strap_nvm_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      u_host.wr(AUN_CTRL_ADDR, 8'h02);
      chk_reg(AUN_CTRL_ADDR, 8'h02, 8'h00);
      wait_idle();
      chk(srsts[7:0], 8'h01);
      chk_reg(AUN_ERR_ADDR, 8'h01, 8'h01);
      $display("test error reload done");
      u_host.wr(AUN_SYS_ADDR, 8'h00);
      u_host.wr(AUN_CLKIN_ADDR, 8'h10);
      u_host.wr(AUN_CTRL_ADDR, 8'h00);
      u_host.wr(AUN_STORE_ADDR, 8'h01);
      chk_reg(AUN_STAT_ADDR, 8'h01, 8'h00);
      u_host.wr(AUN_CTRL_ADDR, 8'h01);
      u_host.wr(AUN_STORE_ADDR, 8'h01);
      chk_reg(AUN_STAT_ADDR, 8'h01, 8'h01);
      chk_reg(AUN_STORE_ADDR, 8'h01, 8'h01);
      wait_idle();
      chk_reg(AUN_STORE_ADDR, 8'h01, 8'h00);
      $display("test store done");
      u_host.wr(AUN_SYS_ADDR, 8'h06);
      u_host.wr(AUN_UPD_ADDR, 8'h01);
      @(negedge clk_in);
      chk(pins, 8'h1E);
      u_host.wr(AUN_CTRL_ADDR, 8'h02);
      chk_reg(AUN_STAT_ADDR, 8'h01, 8'h01);
      wait_idle();
      chk(srsts[7:0], 8'h02);
      chk_reg(AUN_SYS_ADDR, 8'hFF, 8'h00);
      chk(pins, 8'h12);
      chk_reg(AUN_ERR_ADDR, 8'h01, 8'h00);
      $display("test restore done");
      complete_run();
   end
endmodule : align_update_nvm_control_test
bind aun_ctrl aun_ctrl_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rdata_out(reg_rdata_out), .runt_suppress_out(runt_suppress_out),
   .align_pd_out(align_pd_out), .dist_ref_pd_out(dist_ref_pd_out),
   .clkin_pd_out(clkin_pd_out), .align_hold_out(align_hold_out),
   .align_trigger_out(align_trigger_out), .soft_reset_out(soft_reset_out));
